// [design/sdl_host.sv]
// Bus master end: queues words and sends them over the three-wire link.
`timescale 1ns/1ps
module sdl_host
   import sdl_pkg::*;
(
   input  wire logic                       clk_sys,
   input  wire logic                       rst_n,
   sdl_link_if.host                        link,
   input  wire logic [sdl_pkg::WORD_W-1:0] wr_data,
   input  wire logic                       wr_valid,
   output logic                            wr_ready,
   input  wire logic                       strobe_mode,
   output logic                            busy
);
   typedef struct packed {
      sdl_hstate_t         st;
      logic [WORD_W-1:0]   word;
      logic [CNT_W-1:0]    bits;
      logic [CNT_W-1:0]    cnt;
      logic                ph;
      logic                sclk;
      logic                cs_n;
      logic                sdi;
      logic                latch_update_strobe_n_n;
   } sdl_host_st_t;

   sdl_host_st_t        r;
   sdl_host_st_t        r_nxt;
   logic [WORD_W-1:0]   q_data;
   logic                q_valid;
   logic                q_pop;

   // The queue stalls the user once the link falls behind.
   sdl_fifo #(
      .WIDTH (WORD_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .in_data   (wr_data),
      .in_valid  (wr_valid),
      .in_ready  (wr_ready),
      .out_data  (q_data),
      .out_valid (q_valid),
      .out_ready (q_pop)
   );

   assign link.cs_n = r.cs_n;
   assign link.sclk = r.sclk;
   assign link.sdi = r.sdi;
   assign link.latch_update_strobe_n = r.latch_update_strobe_n_n;
   assign busy = (r.st != H_IDLE) || q_valid;
   assign q_pop = (r.st == H_IDLE) && q_valid;

   // Serial clock is clk_sys divided by two; data moves on its falling edge.
   always_comb begin
      r_nxt = r;
      case (r.st)
         H_IDLE: begin
            r_nxt.latch_update_strobe_n_n = strobe_mode;
            if (q_valid) begin
               r_nxt.word = q_data;
               r_nxt.cs_n = 1'b0;
               r_nxt.sdi = q_data[WORD_W-1];
               r_nxt.bits = '0;
               r_nxt.ph = 1'b0;
               r_nxt.st = H_SHIFT;
            end
         end
         H_SHIFT: begin
            if (!r.ph) begin
               r_nxt.sclk = 1'b1;
               r_nxt.ph = 1'b1;
            end else begin
               r_nxt.sclk = 1'b0;
               r_nxt.ph = 1'b0;
               // Only whole frames are ever sent, so no word needs resending.
               if (r.bits == LAST_BIT) begin
                  r_nxt.cs_n = 1'b1;
                  r_nxt.cnt = '0;
                  r_nxt.st = H_DLY;
               end else begin
                  r_nxt.bits = r.bits + 1'b1;
                  r_nxt.word = {r.word[WORD_W-2:0], 1'b0};
                  r_nxt.sdi = r.word[WORD_W-2];
               end
            end
         end
         H_DLY: begin
            r_nxt.cnt = r.cnt + 1'b1;
            if (r.cnt == DLY_CNT) begin
               r_nxt.cnt = '0;
               r_nxt.st = strobe_mode ? H_LATCH_UPDATE_STROBE_N : H_GAP;
               // Pulse mode raises it again later; tied mode keeps it low.
               r_nxt.latch_update_strobe_n_n = 1'b0;
            end
         end
         H_LATCH_UPDATE_STROBE_N: begin
            r_nxt.cnt = r.cnt + 1'b1;
            if (r.cnt == LATCH_UPDATE_STROBE_N_CNT) begin
               r_nxt.cnt = '0;
               r_nxt.latch_update_strobe_n_n = 1'b1;
               r_nxt.st = H_GAP;
            end
         end
         H_GAP: begin
            r_nxt.cnt = r.cnt + 1'b1;
            if (r.cnt == GAP_CNT) begin
               r_nxt.st = H_IDLE;
            end
         end
         default: begin
            r_nxt.st = H_IDLE;
         end
      endcase
   end

   // Reset leaves select and strobe high and the clock low.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         r <= '{st: H_IDLE, word: '0, bits: '0, cnt: '0, ph: 1'b0,
                sclk: 1'b0, cs_n: 1'b1, sdi: 1'b0, latch_update_strobe_n_n: 1'b1};
      end else begin
         r <= r_nxt;
      end
   end
endmodule

// [design/sdl_pkg.sv]
// Shared constants and types for the serial converter input and latch path.
package sdl_pkg;

   localparam int unsigned WORD_W = 16;
   localparam int unsigned CNT_W = 5;
   localparam int unsigned FIFO_DEPTH = 16;

   // Values after reset, and the index of the last frame bit.
   localparam logic [WORD_W-1:0] INREG_RST = 16'h0000;
   localparam logic [WORD_W-1:0] LATCH_RST = 16'h0000;
   localparam logic [CNT_W-1:0] LAST_BIT = 5'h0F;

   // Offset binary midpoint, used to centre the bipolar level.
   localparam logic [17:0] BIP_ZERO = 18'h10000;

   // System clock and link timing, times in ns.
   localparam int unsigned CLK_SYS_PERIOD_NS = 25;
   localparam int unsigned T_DLDAC_NS = 30;
   localparam int unsigned T_WLDAC_NS = 30;
   localparam int unsigned T_CS_GAP_NS = 30;

   // Least times round up to whole cycles.
   localparam int unsigned T_DLDAC_CYC = (T_DLDAC_NS + CLK_SYS_PERIOD_NS - 1) / CLK_SYS_PERIOD_NS;
   localparam int unsigned T_WLDAC_CYC = (T_WLDAC_NS + CLK_SYS_PERIOD_NS - 1) / CLK_SYS_PERIOD_NS;
   localparam int unsigned T_CS_GAP_CYC = (T_CS_GAP_NS + CLK_SYS_PERIOD_NS - 1) / CLK_SYS_PERIOD_NS;

   // The device needs three sampling stages plus agreement to see a level.
   localparam int unsigned SYNC_MARGIN_CYC = 6;
   localparam logic [CNT_W-1:0] DLY_CNT = CNT_W'(T_DLDAC_CYC - 1);
   localparam logic [CNT_W-1:0] LATCH_UPDATE_STROBE_N_CNT = CNT_W'(T_WLDAC_CYC + 2 - 1);
   localparam logic [CNT_W-1:0] GAP_CNT = CNT_W'(T_CS_GAP_CYC + SYNC_MARGIN_CYC - 1);

   // Host sequencer states.
   typedef enum logic [2:0] {
      H_IDLE,
      H_SHIFT,
      H_DLY,
      H_LATCH_UPDATE_STROBE_N,
      H_GAP
   } sdl_hstate_t;

endpackage

// [design/sdl_link_if.sv]
// Three-wire link plus latch update strobe between master and converter.
`timescale 1ns/1ps
interface sdl_link_if;
   logic cs_n;
   logic sclk;
   logic sdi;
   logic latch_update_strobe_n;

   // Master end drives every wire.
   modport host (
      output cs_n,
      output sclk,
      output sdi,
      output latch_update_strobe_n
   );

   // Converter end only listens.
   modport dev (
      input cs_n,
      input sclk,
      input sdi,
      input latch_update_strobe_n
   );
endinterface

// [design/sdl_fifo.sv]
// Word FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module sdl_fifo #(
   parameter int unsigned WIDTH = 16,
   parameter int unsigned DEPTH = 16
) (
   input  wire logic             clk_sys,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int unsigned AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW:0]                 wptr;
      logic [AW:0]                 rptr;
   } sdl_fifo_st_t;

   sdl_fifo_st_t r;
   sdl_fifo_st_t r_nxt;
   logic         full;
   logic         empty;

   // Extra pointer bit tells full from empty when the indices meet.
   assign empty = (r.wptr == r.rptr);
   assign full = (r.wptr[AW-1:0] == r.rptr[AW-1:0]) && (r.wptr[AW] != r.rptr[AW]);
   assign in_ready = !full;
   assign out_valid = !empty;
   assign out_data = r.mem[r.rptr[AW-1:0]];

   // Push and pop may happen in the same cycle.
   always_comb begin
      r_nxt = r;
      if (in_valid && !full) begin
         r_nxt.mem[r.wptr[AW-1:0]] = in_data;
         r_nxt.wptr = r.wptr + 1'b1;
      end
      if (out_ready && !empty) begin
         r_nxt.rptr = r.rptr + 1'b1;
      end
   end

   // Storage is cleared too so no unknown word can leave after reset.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         r <= '0;
      end else begin
         r <= r_nxt;
      end
   end
endmodule

// [design/sdl_dev.sv]
// Converter end: serial shift register, input register and output latch.
`timescale 1ns/1ps
module sdl_dev
   import sdl_pkg::*;
(
   input  wire logic                       clk_sys,
   input  wire logic                       rst_n,
   sdl_link_if.dev                         link,
   input  wire logic                       use_update_strobe,
   input  wire logic                       bipolar,
   output logic      [sdl_pkg::WORD_W-1:0] input_word,
   output logic      [sdl_pkg::WORD_W-1:0] dac_code,
   output logic signed [17:0]              out_level,
   output logic                            load_pulse,
   output logic                            update_pulse
);
   // Channel indices of the sampled link levels.
   localparam int unsigned CH_CS = 0;
   localparam int unsigned CH_LD = 1;
   localparam int unsigned NCH = 2;

   // Link clock domain state: only the shift register lives here.
   typedef struct packed {
      logic [WORD_W-1:0] shreg;
   } sdl_dev_lnk_t;

   // System clock domain state.
   typedef struct packed {
      logic [NCH-1:0][2:0] sy;
      logic [NCH-1:0]      lvl;
      logic [WORD_W-1:0]   in_reg;
      logic [WORD_W-1:0]   latch;
      logic [17:0]         level;
      logic                load;
      logic                upd;
   } sdl_dev_sys_t;

   sdl_dev_lnk_t        l;
   sdl_dev_lnk_t        l_nxt;
   sdl_dev_sys_t        r;
   sdl_dev_sys_t        r_nxt;
   logic [NCH-1:0]      pin;
   logic                cs_rise;
   logic                ld_low;
   logic [WORD_W-1:0]   latch_new;

   assign pin[CH_CS] = link.cs_n;
   assign pin[CH_LD] = link.latch_update_strobe_n;

   assign input_word = r.in_reg;
   assign dac_code = r.latch;
   assign out_level = $signed(r.level);
   assign load_pulse = r.load;
   assign update_pulse = r.upd;

   // ---------------------------------------------------------------
   // Link clock domain.
   // ---------------------------------------------------------------

   // Shift only while selected; the newest bit enters at the bottom so
   // the first bit sent ends up on top and extra bits push old ones out.
   always_comb begin
      l_nxt = l;
      if (!link.cs_n) begin
         l_nxt.shreg = {l.shreg[WORD_W-2:0], link.sdi};
      end
   end

   // No reset here: the shift register powers up undefined, and the link
   // clock may stand still, so nothing may wait on one of its edges.
   always_ff @(posedge link.sclk) begin
      l <= l_nxt;
   end

   // ---------------------------------------------------------------
   // System clock domain.
   // ---------------------------------------------------------------

   // A select rise seen in the filtered level marks the end of a frame.
   // The shift register is quiet from then on, since shifting is gated
   // by select, so it is read here as a stable, qualified word.
   // Taken from the stages directly, so no loop through the next state.
   assign cs_rise = !r.lvl[CH_CS] && (r.sy[CH_CS][1] == r.sy[CH_CS][2])
                    && r.sy[CH_CS][2];
   assign ld_low = !r.lvl[CH_LD] && r.lvl[CH_CS];

   // The next latch value: follows every load in the plain variant,
   // otherwise follows the input register while the strobe is low and
   // select is high, which also covers a strobe tied low.
   always_comb begin
      latch_new = r.latch;
      if (!use_update_strobe) begin
         if (cs_rise) begin
            latch_new = l.shreg;
         end
      end else if (ld_low) begin
         latch_new = r.in_reg;
      end
   end

   // Sampling, edge detection and register updates.
   always_comb begin
      r_nxt = r;
      // Three stages per level; only the second and third are compared,
      // so the first stage never feeds any logic but the second.
      for (int i = 0; i < NCH; i++) begin
         r_nxt.sy[i] = {r.sy[i][1:0], pin[i]};
         if (r.sy[i][1] == r.sy[i][2]) begin
            r_nxt.lvl[i] = r.sy[i][2];
         end
      end
      r_nxt.load = 1'b0;
      r_nxt.upd = 1'b0;
      if (cs_rise) begin
         r_nxt.in_reg = l.shreg;
         r_nxt.load = 1'b1;
      end
      r_nxt.latch = latch_new;
      if (latch_new != r.latch) begin
         r_nxt.upd = 1'b1;
      end
      // Output level in steps of the reference over 65536.
      if (bipolar) begin
         r_nxt.level = {1'b0, latch_new, 1'b0} - BIP_ZERO;
      end else begin
         r_nxt.level = {2'b00, latch_new};
      end
   end

   // Reset clears the input register and the latch; both link levels
   // start idle high so no false frame end is seen at release.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         r <= '{sy: '1, lvl: '1, in_reg: INREG_RST, latch: LATCH_RST,
                level: 18'h00000, load: 1'b0, upd: 1'b0};
      end else begin
         r <= r_nxt;
      end
   end

   // Note: the bipolar level at reset reads as zero for one cycle, then
   // settles to minus full scale because the latch is zero code.
endmodule

// [dv/sdl_link_assertions.sv]
// Concurrent checks on the host-to-converter link and the converter's outputs.
`timescale 1ns/1ps
module sdl_link_chk
   import sdl_pkg::*;
(
   input  wire logic                       clk_sys,
   input  wire logic                       rst_n,
   input  wire logic                       cs_n,
   input  wire logic                       sclk,
   input  wire logic                       sdi,
   input  wire logic                       latch_update_strobe_n,
   input  wire logic                       use_update_strobe,
   input  wire logic                       bipolar,
   input  wire logic [sdl_pkg::WORD_W-1:0] input_word,
   input  wire logic [sdl_pkg::WORD_W-1:0] dac_code,
   input  wire logic signed [17:0]         out_level,
   input  wire logic                       load_pulse,
   input  wire logic                       update_pulse
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   logic [4:0] rise_cnt_r;
   logic       sclk_q_r;

   // Counts link clock rises per frame; the host derives that clock from ours, so no loss.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rise_cnt_r <= 5'h00;
         sclk_q_r   <= 1'b0;
      end else begin
         sclk_q_r <= sclk;
         if (cs_n)
            rise_cnt_r <= 5'h00;
         else if (sclk && !sclk_q_r)
            rise_cnt_r <= rise_cnt_r + 5'h01;
      end
   end

   sclk_idle_a: assert property (cs_n |-> !sclk)
      else $error("link clock high while chip select high");
   data_on_fall_a: assert property (!cs_n && $changed(sdi) |-> $fell(sclk) || $fell(cs_n))
      else $error("serial data changed away from a falling link clock");
   frame_len_a: assert property ($rose(cs_n) |-> rise_cnt_r == 5'h10)
      else $error("frame closed without exactly sixteen clocks");
   load_after_rise_a: assert property ($rose(cs_n) |-> ##[3:6] load_pulse)
      else $error("no input register load after chip select rose");
   load_cause_a: assert property (load_pulse |-> cs_n && $past(cs_n, 3))
      else $error("input register loaded while selected");
   word_on_load_a: assert property ($changed(input_word) |-> load_pulse)
      else $error("input register changed without a load");
   latch_direct_a: assert property (!use_update_strobe && load_pulse |-> dac_code == input_word)
      else $error("latch did not follow the load");
   latch_frozen_a: assert property ($changed(dac_code) |-> cs_n)
      else $error("latch changed while selected");
   update_flag_a: assert property ($changed(dac_code) |-> update_pulse)
      else $error("latch change not flagged");
   strobe_in_gap_a: assert property ($fell(latch_update_strobe_n) |-> cs_n)
      else $error("update strobe fell during a frame");
   level_code_a: assert property (($stable(dac_code) && $stable(bipolar))[*2] |-> out_level ==
      (bipolar ? $signed({1'b0, dac_code, 1'b0}) - 18'sh10000 : $signed({2'b00, dac_code})))
      else $error("output level does not match the latch code");

   cover property ($rose(cs_n));
   cover property (update_pulse && use_update_strobe);
   cover property (load_pulse && bipolar);
endmodule

// [dv/tb_serial_dac_input_and_latch.sv]
// Bench joining host and converter ends, plus a bench-driven link to a second converter.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
$display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module tb_serial_dac_input_and_latch;
   import sdl_pkg::*;
   logic               clk_sys, rst_n, wr_valid, wr_ready, strobe_mode, busy;
   logic               use_update_strobe, bipolar, load_pulse, update_pulse, load_pulse_b;
   logic [15:0]        wr_data, input_word, dac_code, input_word_b, wire_sh;
   logic signed [17:0] out_level;
   logic [15:0]        exp_q[$];
   int                 n_errors, n_tests, cyc, wire_cnt;
   sdl_link_if link_a();
   sdl_link_if link_b();

   sdl_host i_sdl_host (.clk_sys(clk_sys), .rst_n(rst_n), .link(link_a), .wr_data(wr_data),
      .wr_valid(wr_valid), .wr_ready(wr_ready), .strobe_mode(strobe_mode), .busy(busy));
   sdl_dev i_sdl_dev (.clk_sys(clk_sys), .rst_n(rst_n), .link(link_a),
      .use_update_strobe(use_update_strobe), .bipolar(bipolar), .input_word(input_word),
      .dac_code(dac_code), .out_level(out_level), .load_pulse(load_pulse),
      .update_pulse(update_pulse));
   // Second converter faces the bench, which breaks the framing on purpose.
   sdl_dev i_sdl_dev_b (.clk_sys(clk_sys), .rst_n(rst_n), .link(link_b),
      .use_update_strobe(1'b0), .bipolar(1'b0), .input_word(input_word_b), .dac_code(),
      .out_level(), .load_pulse(load_pulse_b), .update_pulse());
   sdl_link_chk i_chk (.clk_sys(clk_sys), .rst_n(rst_n), .cs_n(link_a.cs_n),
      .sclk(link_a.sclk), .sdi(link_a.sdi), .latch_update_strobe_n(link_a.latch_update_strobe_n),
      .use_update_strobe(use_update_strobe), .bipolar(bipolar), .input_word(input_word),
      .dac_code(dac_code), .out_level(out_level), .load_pulse(load_pulse),
      .update_pulse(update_pulse));

   // System clock, 25 ns period.
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   // Cycle ceiling, well above the roughly 1500 cycles the run needs.
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 30000) begin
         n_errors++;
         summarize();
      end
   end

   // Each input register load must carry the oldest word still in flight.
   always @(posedge clk_sys) begin
      if (rst_n === 1'b1 && load_pulse === 1'b1) begin
         `CHK("input_word", exp_q[0], input_word)
         void'(exp_q.pop_front());
      end
   end

   // Rebuild each frame from the wire to judge bit order and clock count.
   always @(negedge link_a.cs_n) wire_cnt = 0;
   always @(posedge link_a.sclk) begin
      if (link_a.cs_n === 1'b0) begin
         wire_sh = {wire_sh[14:0], link_a.sdi};
         wire_cnt++;
      end
   end
   always @(posedge link_a.cs_n) begin
      if (exp_q.size() != 0) begin
         `CHK("wire_word", exp_q[0], wire_sh)
         `CHK("wire_clocks", 16, wire_cnt)
      end
   end

   task automatic summarize();
      $display("checks %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic wait_hi(ref logic s, input string nm);
      int k;
      k = 0;
      while (s !== 1'b1 && k < 400) begin
         @(negedge clk_sys);
         k++;
      end
      `CHK(nm, 1'b1, s)
   endtask

   task automatic push(input logic [15:0] w);
      int k;
      k = 0;
      while (wr_ready !== 1'b1 && k < 2000) begin
         @(negedge clk_sys);
         k++;
      end
      wr_data = w;
      wr_valid = 1'b1;
      exp_q.push_back(w);
      @(negedge clk_sys);
      wr_valid = 1'b0;
   endtask

   task automatic wait_idle();
      int k;
      k = 0;
      repeat (4) @(negedge clk_sys);
      while ((busy !== 1'b0 || exp_q.size() != 0) && k < 3000) begin
         @(negedge clk_sys);
         k++;
      end
      repeat (8) @(negedge clk_sys);
   endtask

   // Bench frame on the second link: 30 ns link clock; with sel low it clocks while select stays high.
   task automatic frame_b(input logic [31:0] bits, input int n, input logic sel);
      link_b.cs_n = ~sel;
      #20;
      for (int i = n - 1; i >= 0; i--) begin
         link_b.sdi = bits[i];
         #15 link_b.sclk = 1'b1;
         #15 link_b.sclk = 1'b0;
      end
      #15 link_b.sdi = ~link_b.sdi;
      link_b.cs_n = 1'b1;
   endtask

   task automatic t_direct();
      logic [15:0] w[4] = '{16'hA5C3, 16'h8000, 16'hFFFF, 16'h0001};
      foreach (w[i]) begin
         push(w[i]);
         wait_idle();
         `CHK("dac_code", w[i], dac_code)
         `CHK("out_uni", $signed({2'b00, w[i]}), out_level)
      end
   endtask

   task automatic t_bipolar();
      logic [15:0] w[4] = '{16'h0000, 16'h8000, 16'hFFFF, 16'h7FFF};
      bipolar = 1'b1;
      foreach (w[i]) begin
         push(w[i]);
         wait_idle();
         `CHK("out_bip", $signed({1'b0, w[i], 1'b0}) - 18'sh10000, out_level)
      end
      bipolar = 1'b0;
   endtask

   task automatic t_strobe();
      use_update_strobe = 1'b1;
      push(16'h1234);
      wait_hi(load_pulse, "load");
      `CHK("latch_held", 16'h7FFF, dac_code)
      wait_hi(update_pulse, "update");
      `CHK("latch_strobed", 16'h1234, dac_code)
      wait_idle();
      strobe_mode = 1'b0;
      push(16'h0F0F);
      wait_hi(load_pulse, "load");
      repeat (2) @(negedge clk_sys);
      `CHK("latch_tied", 16'h0F0F, dac_code)
      wait_idle();
   endtask

   // Holds the write port busy until the queue refuses, then lets it drain.
   task automatic t_fill();
      int k;
      use_update_strobe = 1'b0;
      strobe_mode = 1'b1;
      wr_valid = 1'b1;
      for (k = 0; k < 40 && wr_ready === 1'b1; k++) begin
         wr_data = 16'h0100 + 16'(k);
         exp_q.push_back(wr_data);
         @(negedge clk_sys);
      end
      wr_valid = 1'b0;
      `CHK("fifo_refuses", 1'b0, wr_ready)
      `CHK("fifo_depth", 1'b1, k >= FIFO_DEPTH)
      wait_idle();
      `CHK("fifo_drained", 1'b1, wr_ready)
   endtask

   task automatic t_link_b();
      frame_b(32'h000ABCDE, 20, 1'b1);
      wait_hi(load_pulse_b, "load_b");
      `CHK("extra_clocks", 16'hBCDE, input_word_b)
      repeat (10) @(negedge clk_sys);
      frame_b(32'h000000FF, 8, 1'b0);
      @(negedge clk_sys);
      frame_b(32'h0000005A, 8, 1'b1);
      wait_hi(load_pulse_b, "load_b");
      `CHK("short_frame", 16'hDE5A, input_word_b)
   endtask

   task automatic t_reset();
      rst_n = 1'b0;
      repeat (3) @(negedge clk_sys);
      `CHK("input_word_rst", 16'h0000, input_word)
      `CHK("dac_code_rst", 16'h0000, dac_code)
      rst_n = 1'b1;
      @(negedge clk_sys);
      push(16'hC001);
      wait_idle();
      `CHK("after_reset", 16'hC001, dac_code)
   endtask

   // Main sequence; every input but the second link's moves on the falling edge.
   initial begin
      rst_n = 1'b0;
      wr_data = 16'h0000;
      wr_valid = 1'b0;
      strobe_mode = 1'b1;
      use_update_strobe = 1'b0;
      bipolar = 1'b0;
      link_b.cs_n = 1'b1;
      link_b.sclk = 1'b0;
      link_b.sdi = 1'b0;
      link_b.latch_update_strobe_n = 1'b1;
      repeat (12) @(negedge clk_sys);
      rst_n = 1'b1;
      @(negedge clk_sys);
      t_direct();
      t_bipolar();
      t_strobe();
      t_fill();
      t_link_b();
      t_reset();
      summarize();
   end
endmodule
